// file: hw/ewp_pkg.sv
// Constants and types shared by the write-protect gate and its helpers.
// Assumes the two-wire framing logic outside hands over whole decoded bytes.
package ewp_pkg;

  localparam logic [3:0] PREAMBLE_ARRAY = 4'hA;
  localparam logic [3:0] PREAMBLE_PROT = 4'h6;
  localparam logic [2:0] REV_SET_SEL = 3'h1;
  localparam logic [2:0] REV_CLR_SEL = 3'h3;
  localparam logic [1:0] REV_SET_PINS = 2'h0;
  localparam logic [1:0] REV_CLR_PINS = 2'h1;
  localparam logic [7:0] UPPER_HALF_BASE = 8'h80;
  localparam int PREAMBLE_MSB = 7;
  localparam int PREAMBLE_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 1;
  localparam int RW_BIT = 0;
  localparam int PIN_A0 = 0;
  localparam logic SYNC_RESET_VAL = 1'b0;

  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_ARRAY,
    KIND_PERM,
    KIND_REV_SET,
    KIND_REV_CLR
  } ewp_kind_t;

endpackage

// file: hw/ewp_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous pins; output changes only when stages two and three agree.
`timescale 1ns/1ps
module ewp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s1_r <= {WIDTH{ewp_pkg::SYNC_RESET_VAL}};
      s2_r <= {WIDTH{ewp_pkg::SYNC_RESET_VAL}};
      s3_r <= {WIDTH{ewp_pkg::SYNC_RESET_VAL}};
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Each bit settles on its own so a slow edge on one pin does not hold the others.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          sync_o[g] <= ewp_pkg::SYNC_RESET_VAL;
        end else if (s2_r[g] == s3_r[g]) begin
          sync_o[g] <= s3_r[g];
        end
      end
    end
  endgenerate

endmodule

// file: hw/ewp_decode.sv
// Combinational classifier for the device address byte.
// Assumes pin levels arrive already synchronised.
`timescale 1ns/1ps
module ewp_decode (
  input wire logic [7:0] ctrl_byte_i,
  input wire logic [2:0] addr_pins_i,
  input wire logic hv_a0_i,
  output ewp_pkg::ewp_kind_t kind_o,
  output logic rd_o
);

  logic [3:0] pre;
  logic [2:0] sel;

  always_comb begin
    pre = ctrl_byte_i[ewp_pkg::PREAMBLE_MSB:ewp_pkg::PREAMBLE_LSB];
    sel = ctrl_byte_i[ewp_pkg::SEL_MSB:ewp_pkg::SEL_LSB];
    rd_o = ctrl_byte_i[ewp_pkg::RW_BIT];
    kind_o = ewp_pkg::KIND_NONE;
    if (pre == ewp_pkg::PREAMBLE_ARRAY && sel == addr_pins_i) begin
      kind_o = ewp_pkg::KIND_ARRAY;
    end else if (pre == ewp_pkg::PREAMBLE_PROT) begin
      // The high voltage on pin zero is what separates the reversible flag from the permanent one.
      if (hv_a0_i) begin
        if (sel == ewp_pkg::REV_SET_SEL && addr_pins_i[2:1] == ewp_pkg::REV_SET_PINS) begin
          kind_o = ewp_pkg::KIND_REV_SET;
        end else if (sel == ewp_pkg::REV_CLR_SEL && !rd_o
                     && addr_pins_i[2:1] == ewp_pkg::REV_CLR_PINS) begin
          kind_o = ewp_pkg::KIND_REV_CLR;
        end
      end else if (sel == addr_pins_i) begin
        kind_o = ewp_pkg::KIND_PERM;
      end
    end
  end

endmodule

// file: hw/ewp_gate.sv
// Write-protect decision logic for a small two-wire serial memory.
// Assumes framing logic outside delivers address bytes, data-word writes and stop events as pulses.
`timescale 1ns/1ps
module ewp_gate (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wp_pin_i,
  input wire logic hv_a0_i,
  input wire logic [2:0] addr_pins_i,
  input wire logic perm_flag_i,
  input wire logic rev_flag_i,
  input wire logic ctrl_valid_i,
  input wire logic [7:0] ctrl_byte_i,
  input wire logic word_valid_i,
  input wire logic [7:0] word_addr_i,
  input wire logic stop_i,
  output logic ack_valid_o,
  output logic ack_o,
  output logic commit_valid_o,
  output logic commit_o,
  output logic [7:0] commit_addr_o,
  output logic prog_perm_o,
  output logic set_rev_o,
  output logic clr_rev_o,
  output logic wcycle_start_o
);

  logic wp_s;
  logic hv_s;
  logic [2:0] pins_s;
  ewp_pkg::ewp_kind_t dec_kind;
  logic dec_rd;
  logic dec_ack;
  ewp_pkg::ewp_kind_t kind_r;
  ewp_pkg::ewp_kind_t kind_nxt;
  logic rd_r;
  logic wr_ok;
  logic stop_wr;
  logic arr_wr;

  ewp_sync #(.WIDTH(5)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({wp_pin_i, hv_a0_i, addr_pins_i}),
    .sync_o({wp_s, hv_s, pins_s})
  );

  ewp_decode u_decode (
    .ctrl_byte_i(ctrl_byte_i),
    .addr_pins_i(pins_s),
    .hv_a0_i(hv_s),
    .kind_o(dec_kind),
    .rd_o(dec_rd)
  );

  // The flags come straight from nonvolatile cells and are steady, so no synchroniser is spent on them.
  always_comb begin
    case (dec_kind)
      ewp_pkg::KIND_ARRAY: dec_ack = 1'b1;
      ewp_pkg::KIND_PERM: dec_ack = !perm_flag_i;
      ewp_pkg::KIND_REV_SET: dec_ack = !rev_flag_i;
      ewp_pkg::KIND_REV_CLR: dec_ack = !perm_flag_i;
      default: dec_ack = 1'b0;
    endcase
  end

  // A refused byte leaves nothing pending, so the following stop has no effect.
  always_comb begin
    kind_nxt = kind_r;
    if (ctrl_valid_i) begin
      kind_nxt = dec_ack ? dec_kind : ewp_pkg::KIND_NONE;
    end else if (stop_i) begin
      kind_nxt = ewp_pkg::KIND_NONE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      kind_r <= ewp_pkg::KIND_NONE;
      rd_r <= 1'b0;
    end else begin
      kind_r <= kind_nxt;
      if (ctrl_valid_i) begin
        rd_r <= dec_rd;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack_valid_o <= 1'b0;
      ack_o <= 1'b0;
    end else begin
      ack_valid_o <= ctrl_valid_i;
      ack_o <= ctrl_valid_i && dec_ack;
    end
  end

  always_comb begin
    wr_ok = !wp_s && (!(perm_flag_i || rev_flag_i) || word_addr_i >= ewp_pkg::UPPER_HALF_BASE);
  end

  // True when the pending command is of the wanted kind and the qualifier holds.
  function automatic logic pend_hit(input ewp_pkg::ewp_kind_t pend, input ewp_pkg::ewp_kind_t want, input logic qual);
    pend_hit = qual && pend == want;
  endfunction

  // Reads leave nothing to do at stop, and a stop that meets a new address byte is dropped.
  always_comb begin
    stop_wr = stop_i && !ctrl_valid_i && !rd_r;
    arr_wr = pend_hit(kind_r, ewp_pkg::KIND_ARRAY, !rd_r);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      commit_valid_o <= 1'b0;
      commit_o <= 1'b0;
      commit_addr_o <= 8'h00;
    end else begin
      commit_valid_o <= word_valid_i && arr_wr;
      commit_o <= word_valid_i && arr_wr && wr_ok;
      if (word_valid_i) begin
        commit_addr_o <= word_addr_i;
      end
    end
  end

  // Flag changes (only with the protect pin low) and the write-cycle start happen on the stop that closes an acknowledged write.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prog_perm_o <= 1'b0;
      set_rev_o <= 1'b0;
      clr_rev_o <= 1'b0;
      wcycle_start_o <= 1'b0;
    end else begin
      prog_perm_o <= pend_hit(kind_r, ewp_pkg::KIND_PERM, stop_wr) && !wp_s;
      set_rev_o <= pend_hit(kind_r, ewp_pkg::KIND_REV_SET, stop_wr) && !wp_s;
      clr_rev_o <= pend_hit(kind_r, ewp_pkg::KIND_REV_CLR, stop_wr) && !wp_s;
      wcycle_start_o <= stop_wr && kind_r != ewp_pkg::KIND_NONE;
    end
  end

  property p_perm_refused;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_valid_i && dec_kind == ewp_pkg::KIND_PERM && perm_flag_i |=> ack_valid_o && !ack_o;
  endproperty
  a_perm_refused: assert property (p_perm_refused) else $error("permanent command acknowledged while set");

  property p_perm_status;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_valid_i && dec_kind == ewp_pkg::KIND_PERM && !perm_flag_i |=> ack_o;
  endproperty
  a_perm_status: assert property (p_perm_status) else $error("permanent command not acknowledged");

  property p_rev_refused;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_valid_i && dec_kind == ewp_pkg::KIND_REV_SET && rev_flag_i |=> !ack_o;
  endproperty
  a_rev_refused: assert property (p_rev_refused) else $error("reversible command acknowledged while set");

  property p_rev_status;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_valid_i && dec_kind == ewp_pkg::KIND_REV_SET && !rev_flag_i |=> ack_o;
  endproperty
  a_rev_status: assert property (p_rev_status) else $error("reversible command not acknowledged");

  property p_clr_refused;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_valid_i && dec_kind == ewp_pkg::KIND_REV_CLR |=> ack_o == !$past(perm_flag_i);
  endproperty
  a_clr_refused: assert property (p_clr_refused) else $error("clear acknowledge wrong");

  property p_low_half_safe;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      commit_o |-> commit_addr_o >= ewp_pkg::UPPER_HALF_BASE || (!$past(perm_flag_i) && !$past(rev_flag_i));
  endproperty
  a_low_half_safe: assert property (p_low_half_safe) else $error("lower half written under protection");

  property p_full_array;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      word_valid_i && kind_r == ewp_pkg::KIND_ARRAY && !rd_r && !wp_s && !perm_flag_i && !rev_flag_i |=> commit_o;
  endproperty
  a_full_array: assert property (p_full_array) else $error("unprotected write not committed");

  property p_pin_high;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      wp_s && $stable(wp_s) |=> !commit_o && !prog_perm_o && !set_rev_o && !clr_rev_o;
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("change while pin high");

  property p_wcycle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      prog_perm_o || set_rev_o || clr_rev_o |-> wcycle_start_o;
  endproperty
  a_wcycle: assert property (p_wcycle) else $error("flag change without write cycle");

  property p_array_ack;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_valid_i && dec_kind == ewp_pkg::KIND_ARRAY |=> ack_valid_o && ack_o;
  endproperty
  a_array_ack: assert property (p_array_ack) else $error("array address byte not acknowledged");

  property p_unmatched;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_valid_i && dec_kind == ewp_pkg::KIND_NONE |=> ack_valid_o && !ack_o;
  endproperty
  a_unmatched: assert property (p_unmatched) else $error("unmatched address byte acknowledged");

  property p_ack_timing;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ack_valid_o |-> $past(ctrl_valid_i);
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("acknowledge without address byte");

  property p_refused_idle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_valid_i && !dec_ack |=> kind_r == ewp_pkg::KIND_NONE;
  endproperty
  a_refused_idle: assert property (p_refused_idle) else $error("refused byte left a command pending");

  property p_perm_done;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      stop_wr && kind_r == ewp_pkg::KIND_PERM && !wp_s |=> prog_perm_o;
  endproperty
  a_perm_done: assert property (p_perm_done) else $error("permanent flag not programmed");

  property p_rev_set_done;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      stop_wr && kind_r == ewp_pkg::KIND_REV_SET && !wp_s |=> set_rev_o;
  endproperty
  a_rev_set_done: assert property (p_rev_set_done) else $error("reversible flag not set");

  property p_rev_clr_done;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      stop_wr && kind_r == ewp_pkg::KIND_REV_CLR && !wp_s |=> clr_rev_o;
  endproperty
  a_rev_clr_done: assert property (p_rev_clr_done) else $error("reversible flag not cleared");

  property p_pin_high_flags;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      stop_i && wp_s |=> !prog_perm_o && !set_rev_o && !clr_rev_o;
  endproperty
  a_pin_high_flags: assert property (p_pin_high_flags) else $error("flag changed at stop while pin high");

  property p_prog_pin_low;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      prog_perm_o || set_rev_o || clr_rev_o |-> !$past(wp_s);
  endproperty
  a_prog_pin_low: assert property (p_prog_pin_low) else $error("flag changed with pin high");

  property p_pin_high_array;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      word_valid_i && wp_s |=> !commit_o;
  endproperty
  a_pin_high_array: assert property (p_pin_high_array) else $error("array stored while pin high");

  property p_upper_half;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      word_valid_i && arr_wr && !wp_s && word_addr_i >= ewp_pkg::UPPER_HALF_BASE |=> commit_o;
  endproperty
  a_upper_half: assert property (p_upper_half) else $error("upper half write not stored");

  property p_commit_addr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      word_valid_i |=> commit_addr_o == $past(word_addr_i);
  endproperty
  a_commit_addr: assert property (p_commit_addr) else $error("commit address not captured");

  property p_commit_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      commit_valid_o |-> $past(arr_wr) && $past(word_valid_i);
  endproperty
  a_commit_write: assert property (p_commit_write) else $error("commit outside an array write");

  property p_blocked_cycle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      stop_wr && kind_r == ewp_pkg::KIND_ARRAY |=> wcycle_start_o;
  endproperty
  a_blocked_cycle: assert property (p_blocked_cycle) else $error("array write without write cycle");

  property p_read_quiet;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      stop_i && rd_r |=> !wcycle_start_o && !prog_perm_o && !set_rev_o && !clr_rev_o;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read stop started an action");

  c_array_write: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) commit_o);
  c_blocked_write: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) commit_valid_o && !commit_o);
  c_prog_perm: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) prog_perm_o);
  c_clr_rev: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) clr_rev_o);
  c_refused: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) ack_valid_o && !ack_o);

endmodule

// file: testbench/ewp_host_model.sv
// Two-wire host model that hands decoded address bytes, data words and stops to the gate.
// Assumes one clock shared with the gate; requests change 1 ns after a rising edge.
`timescale 1ns/1ps
module ewp_host_model #(
  parameter int WR_CYCLES = 4
) (
  input wire logic core_clk_i,
  input wire logic ack_valid_i,
  input wire logic ack_i,
  input wire logic commit_valid_i,
  input wire logic commit_i,
  input wire logic prog_perm_i,
  input wire logic set_rev_i,
  input wire logic clr_rev_i,
  input wire logic wcycle_start_i,
  output logic ctrl_valid_o,
  output logic [7:0] ctrl_byte_o,
  output logic word_valid_o,
  output logic [7:0] word_addr_o,
  output logic stop_o
);
  initial begin
    ctrl_valid_o = 1'b0;
    ctrl_byte_o = 8'h00;
    word_valid_o = 1'b0;
    word_addr_o = 8'h00;
    stop_o = 1'b0;
  end

  // Result bits: ack valid, ack, commit valid, commit, program, set, clear, write cycle.
  task automatic run(input logic [7:0] cb, input logic [7:0] wa, input logic do_word, output logic [7:0] res);
    logic av, ak, cv, cm;
    begin
      cv = 1'b0;
      cm = 1'b0;
      @(posedge core_clk_i);
      #1;
      ctrl_valid_o = 1'b1;
      ctrl_byte_o = cb;
      @(posedge core_clk_i);
      #1;
      ctrl_valid_o = 1'b0;
      // Stale bytes are inverted so a gate that reads outside the strobe is caught.
      ctrl_byte_o = ~cb;
      av = ack_valid_i;
      ak = ack_i;
      if (do_word) begin
        word_valid_o = 1'b1;
        word_addr_o = wa;
        @(posedge core_clk_i);
        #1;
        word_valid_o = 1'b0;
        word_addr_o = ~wa;
        cv = commit_valid_i;
        cm = commit_i;
      end
      stop_o = 1'b1;
      @(posedge core_clk_i);
      #1;
      stop_o = 1'b0;
      res = {av, ak, cv, cm, prog_perm_i, set_rev_i, clr_rev_i, wcycle_start_i};
      // The write time is honoured even when protection blocked the store.
      repeat (WR_CYCLES) @(posedge core_clk_i);
    end
  endtask
endmodule

// file: testbench/ewp_gate_tb_top.sv
// Self-checking bench for the write-protect gate with a host model on its byte side.
// Assumes flag storage is modelled here, updated by the gate's program pulses.
`timescale 1ns/1ps
module ewp_gate_tb_top;
  logic core_clk_i, rst_n_i, wp_pin_i, hv_a0_i, perm_flag_i, rev_flag_i;
  logic [2:0] addr_pins_i;
  logic ctrl_valid, word_valid, stop, ack_valid, ack, commit_valid, commit;
  logic prog_perm, set_rev, clr_rev, wcycle;
  logic [7:0] ctrl_byte, word_addr, commit_addr, res;
  int errors, n_tests;
  int cycles = 0;

  ewp_gate DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wp_pin_i(wp_pin_i), .hv_a0_i(hv_a0_i),
    .addr_pins_i(addr_pins_i), .perm_flag_i(perm_flag_i), .rev_flag_i(rev_flag_i),
    .ctrl_valid_i(ctrl_valid), .ctrl_byte_i(ctrl_byte), .word_valid_i(word_valid),
    .word_addr_i(word_addr), .stop_i(stop), .ack_valid_o(ack_valid), .ack_o(ack),
    .commit_valid_o(commit_valid), .commit_o(commit), .commit_addr_o(commit_addr),
    .prog_perm_o(prog_perm), .set_rev_o(set_rev), .clr_rev_o(clr_rev), .wcycle_start_o(wcycle));

  ewp_host_model HOST (.core_clk_i(core_clk_i), .ack_valid_i(ack_valid), .ack_i(ack),
    .commit_valid_i(commit_valid), .commit_i(commit), .prog_perm_i(prog_perm), .set_rev_i(set_rev),
    .clr_rev_i(clr_rev), .wcycle_start_i(wcycle), .ctrl_valid_o(ctrl_valid), .ctrl_byte_o(ctrl_byte),
    .word_valid_o(word_valid), .word_addr_o(word_addr), .stop_o(stop));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // Nonvolatile flags follow the gate's program pulses; the start-up reset stands in for a blank part.
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      perm_flag_i <= 1'b0;
      rev_flag_i <= 1'b0;
    end else begin
      if (prog_perm) perm_flag_i <= 1'b1;
      if (set_rev) rev_flag_i <= 1'b1;
      if (clr_rev) rev_flag_i <= 1'b0;
    end
  end

  task automatic wrap_up;
    $display("Checks made: %0d, mismatches: %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Pin levels pass a synchroniser, so they settle before the next request.
  task automatic pins(input logic wp, input logic hv, input logic [2:0] a);
    @(posedge core_clk_i);
    #1;
    wp_pin_i = wp;
    hv_a0_i = hv;
    addr_pins_i = a;
    repeat (6) @(posedge core_clk_i);
  endtask

  task automatic op(input logic [7:0] cb, input logic [7:0] wa, input logic w, output logic [7:0] r);
    HOST.run(cb, wa, w, r);
  endtask

  task automatic t_open;
    op(8'hA0, 8'h10, 1'b1, res);
    check(res, 8'hF1);
    check(commit_addr, 8'h10);
    op(8'hA0, 8'h7F, 1'b1, res);
    check(res, 8'hF1);
    op(8'h61, 8'h00, 1'b0, res);
    check(res, 8'hC0);
    pins(1'b0, 1'b1, 3'h1);
    op(8'h63, 8'h00, 1'b0, res);
    check(res, 8'hC0);
  endtask

  task automatic t_rev;
    op(8'h62, 8'h00, 1'b0, res);
    check(res, 8'hC5);
    op(8'h63, 8'h00, 1'b0, res);
    check(res, 8'h80);
    op(8'h62, 8'h00, 1'b0, res);
    check(res, 8'h80);
    pins(1'b0, 1'b0, 3'h0);
    op(8'hA0, 8'h7F, 1'b1, res);
    check(res, 8'hE1);
    op(8'hA0, 8'h80, 1'b1, res);
    check(res, 8'hF1);
    op(8'hA0, 8'hFF, 1'b1, res);
    check(res, 8'hF1);
    pins(1'b0, 1'b1, 3'h3);
    op(8'h66, 8'h00, 1'b0, res);
    check(res, 8'hC3);
    // The clear code is write only; its read form must find no command.
    op(8'h67, 8'h00, 1'b0, res);
    check(res, 8'h80);
    pins(1'b0, 1'b0, 3'h0);
    op(8'hA0, 8'h00, 1'b1, res);
    check(res, 8'hF1);
  endtask

  task automatic t_wp_high;
    pins(1'b1, 1'b0, 3'h0);
    op(8'hA1, 8'h00, 1'b0, res);
    check(res, 8'hC0);
    op(8'hA0, 8'h90, 1'b1, res);
    check(res, 8'hE1);
    op(8'h60, 8'h00, 1'b0, res);
    check(res, 8'hC1);
    pins(1'b1, 1'b1, 3'h1);
    op(8'h62, 8'h00, 1'b0, res);
    check(res, 8'hC1);
    pins(1'b1, 1'b1, 3'h3);
    op(8'h66, 8'h00, 1'b0, res);
    check(res, 8'hC1);
    pins(1'b0, 1'b0, 3'h0);
  endtask

  task automatic t_stray;
    op(8'hA2, 8'h10, 1'b1, res);
    check(res, 8'h80);
    op(8'h20, 8'h10, 1'b1, res);
    check(res, 8'h80);
  endtask

  task automatic t_perm;
    op(8'h60, 8'h00, 1'b0, res);
    check(res, 8'hC9);
    op(8'h61, 8'h00, 1'b0, res);
    check(res, 8'h80);
    op(8'h60, 8'h00, 1'b0, res);
    check(res, 8'h80);
    op(8'hA0, 8'h20, 1'b1, res);
    check(res, 8'hE1);
    pins(1'b0, 1'b1, 3'h3);
    op(8'h66, 8'h00, 1'b0, res);
    check(res, 8'h80);
    pins(1'b1, 1'b0, 3'h0);
    op(8'h61, 8'h00, 1'b0, res);
    check(res, 8'h80);
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    rst_n_i = 1'b0;
    wp_pin_i = 1'b0;
    hv_a0_i = 1'b0;
    addr_pins_i = 3'h0;
    repeat (20) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (6) @(posedge core_clk_i);
    t_open();
    t_rev();
    t_wp_high();
    t_stray();
    t_perm();
    wrap_up();
  end
endmodule
